// *** src/eiw_top.sv ***
`timescale 1ns/1ps
module eiw_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic [eiw_pkg::NUM_LE-1:0] level_or_edge_irq_pins,
    input wire logic [eiw_pkg::NUM_EO-1:0] edge_only_irq_pins,
    input wire logic [eiw_pkg::NUM_PC-1:0] pin_change_port_pins,
    input wire eiw_pkg::eiw_cfg_s cfg,
    input wire eiw_pkg::eiw_cpu_s cpu,
    input wire eiw_pkg::eiw_evt_s evt,
    output eiw_pkg::eiw_req_s irq_reg,
    output logic [eiw_pkg::NUM_SRC-1:0] pend_reg,
    output logic [eiw_pkg::NUM_EO-1:0] ext_flag_reg,
    output logic [eiw_pkg::NUM_PC-1:0] pc_flag_reg,
    output logic wake_reg,
    output logic pd_grant_reg,
    output logic pd_refused_reg
);
    import eiw_pkg::*;

    localparam int NPIN = NUM_LE + NUM_EO + NUM_PC;

    // ==========================================================
    // Pin synchronisation and edge detection
    logic [NPIN-1:0] lvl;
    logic [NPIN-1:0] prev;

    eiw_pin_sync #(.W(NPIN)) u_sync (
        .clk(clk),
        .rst(rst),
        .pin_async({pin_change_port_pins, edge_only_irq_pins,
                    level_or_edge_irq_pins}),
        .pin_level(lvl),
        .pin_prev(prev)
    );

    logic [NUM_EXT-1:0] ext_lvl;
    logic [NUM_EXT-1:0] ext_fall;
    logic [NUM_PC-1:0] pc_chg;
    logic [NUM_LE-1:0] le_fire;
    logic [NUM_EO-1:0] eo_fire;
    logic [NUM_PC-1:0] pc_fire;
    logic pd_block;

    assign ext_lvl = lvl[NUM_EXT-1:0];
    assign ext_fall = prev[NUM_EXT-1:0] & ~ext_lvl;
    assign pc_chg = prev[NPIN-1:NUM_EXT] ^ lvl[NPIN-1:NUM_EXT];
    // Level mode fires every cycle the pin stays low
    assign le_fire = cfg.ext_irq_enable_bit[NUM_LE-1:0]
        & ((cfg.level_mode & ~ext_lvl[NUM_LE-1:0])
        | (~cfg.level_mode & ext_fall[NUM_LE-1:0]));
    assign eo_fire = cfg.ext_irq_enable_bit[NUM_EXT-1:NUM_LE]
        & ext_fall[NUM_EXT-1:NUM_LE];
    assign pc_fire = cfg.pc_enable & pc_chg;
    assign pd_block = |(~ext_lvl & cfg.ext_irq_enable_bit);

    // ==========================================================
    // Source gathering
    logic [NUM_SRC-1:0] set_v;
    logic [NUM_SRC-1:0] ack_v;
    logic [NUM_EO-1:0] ext_flag_next;
    logic [NUM_PC-1:0] pc_flag_next;

    always_comb begin
        set_v = '0;
        set_v[SRC_INT0] = le_fire[0];
        set_v[SRC_INT1] = le_fire[1];
        set_v[SRC_T0] = evt.timer[0];
        set_v[SRC_T1] = evt.timer[1];
        set_v[SRC_T2] = evt.timer[2];
        set_v[SRC_T3] = evt.timer[3];
        set_v[SRC_UART1] = |evt.uart1;
        set_v[SRC_UART2] = |evt.uart2;
        set_v[SRC_ADCTK] = evt.adc_tk;
        set_v[SRC_SPI] = evt.spi;
        set_v[SRC_I2C] = evt.i2c;
        set_v[SRC_PWM] = |evt.pwm;
        ack_v = '0;
        if (cpu.ack) begin
            ack_v[cpu.ack_id] = 1'b1;
        end
    end

    // Per-pin flags of the grouped sources; a new edge beats a clear
    always_comb begin
        ext_flag_next = ext_flag_reg;
        pc_flag_next = pc_flag_reg;
        if (ack_v[SRC_INT29]) begin
            ext_flag_next = '0;
        end
        if (ack_v[SRC_PCHG]) begin
            pc_flag_next = '0;
        end
        ext_flag_next = (ext_flag_next & ~cpu.ext_clear) | eo_fire;
        pc_flag_next = (pc_flag_next & ~cpu.pc_clear) | pc_fire;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_flag_reg <= FLAG_RST;
            pc_flag_reg <= FLAG_RST;
        end else begin
            ext_flag_reg <= ext_flag_next;
            pc_flag_reg <= pc_flag_next;
        end
    end

    // Pending bits hold until vectored or cleared; set wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pend_reg <= PEND_RST;
        end else begin
            for (int i = 0; i < NUM_SRC; i++) begin
                if (i == SRC_INT29) begin
                    pend_reg[i] <= |ext_flag_next;
                end else if (i == SRC_PCHG) begin
                    pend_reg[i] <= |pc_flag_next;
                end else begin
                    pend_reg[i] <= set_v[i]
                        | (pend_reg[i] & ~ack_v[i] & ~cpu.sw_clear[i]);
                end
            end
        end
    end

    // ==========================================================
    // Four-level arbitration
    function automatic logic [ID_W+PRIO_W:0] eiw_pick(
        input logic [NUM_SRC-1:0] cand,
        input logic [NUM_SRC*PRIO_W-1:0] prio
    );
        logic [ID_W+PRIO_W:0] best;
        logic [PRIO_W-1:0] p;
        best = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            p = prio[i*PRIO_W +: PRIO_W];
            // Equal level: the lower index overwrites, so it wins
            if (cand[i] && (!best[ID_W+PRIO_W] ||
                            p >= best[PRIO_W-1:0])) begin
                best = {1'b1, ID_W'(i), p};
            end
        end
        return best;
    endfunction

    logic [ID_W+PRIO_W:0] pick;
    logic pick_ok;

    assign pick = eiw_pick(pend_reg & cfg.src_enable & ~ack_v,
                           cfg.prio);
    // Only a strictly higher level preempts the running handler
    assign pick_ok = pick[ID_W+PRIO_W] && cfg.global_enable
        && (!cpu.in_service || pick[PRIO_W-1:0] > cpu.svc_level);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_reg <= '0;
        end else begin
            irq_reg.req <= pick_ok;
            irq_reg.id <= pick[PRIO_W +: ID_W];
            irq_reg.level <= pick[PRIO_W-1:0];
        end
    end

    // ==========================================================
    // Wake-up and power-down gate
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wake_reg <= 1'b0;
        end else begin
            wake_reg <= cpu.sleeping
                && (|le_fire || |eo_fire || |pc_fire);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pd_grant_reg <= 1'b0;
            pd_refused_reg <= 1'b0;
        end else begin
            pd_grant_reg <= cpu.pd_req && !pd_block;
            pd_refused_reg <= cpu.pd_req && pd_block;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_pd_blocked;
        cpu.pd_req && pd_block;
    endsequence

    sequence s_int1_fall;
        cfg.ext_irq_enable_bit[1] && !cfg.level_mode[1] && ext_fall[1];
    endsequence

    sequence s_int0_low;
        cfg.ext_irq_enable_bit[0] && cfg.level_mode[0] && !ext_lvl[0];
    endsequence

    a_pd_refused: assert property (
        s_pd_blocked |=> pd_refused_reg && !pd_grant_reg)
        else $error("power-down granted with enabled pin low");
    a_pd_granted: assert property (
        cpu.pd_req && !pd_block |=> pd_grant_reg && !pd_refused_reg)
        else $error("power-down not granted");
    a_int1_edge: assert property (
        s_int1_fall |=> pend_reg[SRC_INT1])
        else $error("int1 edge not pended");
    a_int0_level: assert property (
        s_int0_low ##1 s_int0_low |=> pend_reg[SRC_INT0])
        else $error("int0 low level not pended");
    a_eo_falls: assert property (
        eo_fire[0] |=> ext_flag_reg[0] && pend_reg[SRC_INT29])
        else $error("edge-only input not flagged");
    a_eo_no_rise: assert property (
        !ext_flag_reg[1] && !ext_fall[3] && !cpu.ack |=> !ext_flag_reg[1])
        else $error("edge-only flag set without fall");
    a_pc_change: assert property (
        cfg.pc_enable[0] && pc_chg[0] |=> pc_flag_reg[0])
        else $error("pin change not flagged");
    a_wake_pin: assert property (
        cpu.sleeping && eo_fire != '0 |=> wake_reg)
        else $error("no wake on external edge");
    a_sync_delay: assert property (
        (edge_only_irq_pins[0] == 1'b0) [*3] |-> lvl[NUM_LE] == 1'b0)
        else $error("synchroniser lost a stable level");
    a_t0_held: assert property (
        pend_reg[SRC_T0] && !(cpu.ack && cpu.ack_id == ID_W'(SRC_T0))
        && !cpu.sw_clear[SRC_T0] |=> pend_reg[SRC_T0])
        else $error("timer0 pending dropped without clear");
    // The id is the one registered now, so the pending vector and global enable are the old ones
    a_req_valid: assert property (
        irq_reg.req |-> |($past(pend_reg) & (NUM_SRC'(1) << irq_reg.id))
        && $past(cfg.global_enable))
        else $error("request for source not pending");
endmodule

// *** src/eiw_pkg.sv ***
package eiw_pkg;
    // ==========================================================
    // Sizes
    localparam int NUM_SRC = 14;
    localparam int NUM_EXT = 10;
    localparam int NUM_LE = 2;
    localparam int NUM_EO = 8;
    localparam int NUM_PC = 8;
    localparam int PRIO_W = 2;
    localparam int ID_W = 4;

    // ==========================================================
    // Source indices, lower index wins a tie within one level
    localparam int SRC_INT0 = 0;
    localparam int SRC_T0 = 1;
    localparam int SRC_INT1 = 2;
    localparam int SRC_T1 = 3;
    localparam int SRC_UART1 = 4;
    localparam int SRC_T2 = 5;
    localparam int SRC_UART2 = 6;
    localparam int SRC_INT29 = 7;
    localparam int SRC_PCHG = 8;
    localparam int SRC_T3 = 9;
    localparam int SRC_ADCTK = 10;
    localparam int SRC_SPI = 11;
    localparam int SRC_I2C = 12;
    localparam int SRC_PWM = 13;

    // ==========================================================
    // Reset values
    localparam logic PIN_IDLE = 1'b1;
    localparam logic [NUM_SRC-1:0] PEND_RST = 14'h0000;
    localparam logic [NUM_EO-1:0] FLAG_RST = 8'h00;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [NUM_EXT-1:0] ext_irq_enable_bit;
        logic [NUM_LE-1:0] level_mode;
        logic [NUM_PC-1:0] pc_enable;
        logic [NUM_SRC-1:0] src_enable;
        logic [NUM_SRC*PRIO_W-1:0] prio;
        logic global_enable;
    } eiw_cfg_s;

    typedef struct packed {
        logic ack;
        logic [ID_W-1:0] ack_id;
        logic [NUM_SRC-1:0] sw_clear;
        logic [NUM_EO-1:0] ext_clear;
        logic [NUM_PC-1:0] pc_clear;
        logic in_service;
        logic [PRIO_W-1:0] svc_level;
        logic sleeping;
        logic pd_req;
    } eiw_cpu_s;

    typedef struct packed {
        logic [3:0] timer;
        logic [1:0] uart1;
        logic [1:0] uart2;
        logic adc_tk;
        logic spi;
        logic i2c;
        logic [2:0] pwm;
    } eiw_evt_s;

    typedef struct packed {
        logic req;
        logic [ID_W-1:0] id;
        logic [PRIO_W-1:0] level;
    } eiw_req_s;
endpackage

// *** src/eiw_pin_sync.sv ***
`timescale 1ns/1ps
// Two-stage synchroniser plus one history stage for edge detection
module eiw_pin_sync #(
    parameter int W = 18
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] pin_async,
    output logic [W-1:0] pin_level,
    output logic [W-1:0] pin_prev
);
    import eiw_pkg::*;

    logic [W-1:0] meta_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= {W{PIN_IDLE}};
            pin_level <= {W{PIN_IDLE}};
            pin_prev <= {W{PIN_IDLE}};
        end else begin
            meta_reg <= pin_async;
            pin_level <= meta_reg;
            pin_prev <= pin_level;
        end
    end
endmodule

// *** tb/eiw_pin_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// Pin driver
// Pins are pulled up, so they idle high
// They change a little after an edge, off the design's sampling instant
module eiw_pin_model (
    input wire logic clk,
    input wire logic [eiw_pkg::NUM_LE-1:0] le_cmd,
    input wire logic [eiw_pkg::NUM_EO-1:0] eo_cmd,
    input wire logic [eiw_pkg::NUM_PC-1:0] pc_cmd,
    output logic [eiw_pkg::NUM_LE-1:0] le_pin,
    output logic [eiw_pkg::NUM_EO-1:0] eo_pin,
    output logic [eiw_pkg::NUM_PC-1:0] pc_pin
);
    import eiw_pkg::*;
    initial begin
        le_pin = '1;
        eo_pin = '1;
        pc_pin = '1;
    end
    always @(posedge clk) begin
        #3;
        le_pin <= le_cmd;
        eo_pin <= eo_cmd;
        pc_pin <= pc_cmd;
    end
endmodule

// *** tb/eiw_top_tb.sv ***
`timescale 1ns/1ps
module eiw_top_tb;
    import eiw_pkg::*;
    logic clk;
    logic rst;
    logic [NUM_LE-1:0] le_cmd, le_pin;
    logic [NUM_EO-1:0] eo_cmd, eo_pin, ext_flag;
    logic [NUM_PC-1:0] pc_cmd, pc_pin, pc_flag;
    eiw_cfg_s cfg;
    eiw_cpu_s cpu;
    eiw_evt_s evt;
    eiw_req_s irq;
    logic [NUM_SRC-1:0] pend;
    logic wake, grant, refuse;
    int err_total, tests_run, wake_cnt, grant_cnt, refuse_cnt;
    eiw_pin_model pins (.clk(clk), .le_cmd(le_cmd), .eo_cmd(eo_cmd),
        .pc_cmd(pc_cmd), .le_pin(le_pin), .eo_pin(eo_pin), .pc_pin(pc_pin));
    eiw_top dut (.clk(clk), .rst(rst), .level_or_edge_irq_pins(le_pin),
        .edge_only_irq_pins(eo_pin), .pin_change_port_pins(pc_pin),
        .cfg(cfg), .cpu(cpu), .evt(evt), .irq_reg(irq), .pend_reg(pend),
        .ext_flag_reg(ext_flag), .pc_flag_reg(pc_flag), .wake_reg(wake),
        .pd_grant_reg(grant), .pd_refused_reg(refuse));
    // ==========================================================
    // Clock and pulse counters
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        wake_cnt <= wake_cnt + (wake === 1'b1);
        grant_cnt <= grant_cnt + (grant === 1'b1);
        refuse_cnt <= refuse_cnt + (refuse === 1'b1);
    end
    // ==========================================================
    // Helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Pin latency is 3-4 edges, so n is chosen with margin
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset;
        chk(pend, 16'h0000);
        chk({ext_flag, pc_flag}, 16'h0000);
        chk({irq.req, wake, grant, refuse}, 16'h0000);
    endtask
    task automatic t_edge_only;
        @(posedge clk);
        cfg.ext_irq_enable_bit <= 10'h004;
        cpu.sleeping <= 1'b1;
        eo_cmd <= 8'hfc;
        cyc(8);
        chk(ext_flag, 16'h0001);
        chk(pend[SRC_INT29], 16'h0001);
        chk(wake_cnt, 16'h0001);
        @(posedge clk);
        eo_cmd <= 8'hff;
        cpu.ext_clear <= 8'h01;
        @(posedge clk);
        cpu.ext_clear <= 8'h00;
        cyc(8);
        chk({ext_flag, 7'h00, pend[SRC_INT29]}, 16'h0000);
    endtask
    task automatic t_level;
        @(posedge clk);
        cfg.ext_irq_enable_bit <= 10'h003;
        cfg.level_mode <= 2'b01;
        // Awake here: a held low level would wake on every cycle
        cpu.sleeping <= 1'b0;
        le_cmd <= 2'b00;
        cyc(8);
        chk({pend[SRC_INT1], pend[SRC_INT0]}, 16'h0003);
        @(posedge clk);
        cpu.sw_clear <= 14'h0005;
        @(posedge clk);
        cpu.sw_clear <= '0;
        cyc(3);
        chk({pend[SRC_INT1], pend[SRC_INT0]}, 16'h0001);
        @(posedge clk);
        le_cmd <= 2'b11;
        cyc(5);
        @(posedge clk);
        cpu.sw_clear <= 14'h0001;
        @(posedge clk);
        cpu.sw_clear <= '0;
        cyc(3);
        chk(pend[SRC_INT0], 16'h0000);
        chk(wake_cnt, 16'h0001);
    endtask
    task automatic t_pin_change;
        @(posedge clk);
        cfg.pc_enable <= 8'h01;
        cpu.sleeping <= 1'b1;
        pc_cmd <= 8'hfc;
        cyc(8);
        chk({pc_flag, 7'h00, pend[SRC_PCHG]}, 16'h0101);
        @(posedge clk);
        cpu.pc_clear <= 8'h01;
        @(posedge clk);
        cpu.pc_clear <= 8'h00;
        cyc(2);
        chk(pc_flag, 16'h0000);
        pc_cmd <= 8'hff;
        cyc(8);
        chk(pc_flag, 16'h0001);
        chk(wake_cnt, 16'h0003);
    endtask
    task automatic t_power_down;
        @(posedge clk);
        cfg.ext_irq_enable_bit <= 10'h001;
        le_cmd <= 2'b10;
        eo_cmd <= 8'hfe;
        cyc(5);
        @(posedge clk);
        cpu.pd_req <= 1'b1;
        @(posedge clk);
        cpu.pd_req <= 1'b0;
        cyc(3);
        chk({grant_cnt[7:0], refuse_cnt[7:0]}, 16'h0001);
        le_cmd <= 2'b11;
        cyc(5);
        @(posedge clk);
        cpu.pd_req <= 1'b1;
        @(posedge clk);
        cpu.pd_req <= 1'b0;
        cyc(3);
        chk({grant_cnt[7:0], refuse_cnt[7:0]}, 16'h0101);
    endtask
    task automatic t_sources;
        int ids [NUM_SRC] = '{SRC_PWM, SRC_PWM, SRC_PWM, SRC_I2C, SRC_SPI,
            SRC_ADCTK, SRC_UART2, SRC_UART2, SRC_UART1, SRC_UART1, SRC_T0,
            SRC_T1, SRC_T2, SRC_T3};
        @(posedge clk);
        cfg <= '0;
        // Drop what earlier scenarios left pending so each event stands alone
        cpu <= '{sw_clear: '1, ext_clear: '1, pc_clear: '1, default: '0};
        eo_cmd <= 8'hff;
        @(posedge clk);
        cpu <= '0;
        cyc(5);
        for (int k = 0; k < NUM_SRC; k++) begin
            @(posedge clk);
            evt <= eiw_evt_s'(14'h0001 << k);
            @(posedge clk);
            evt <= '0;
            cyc(1);
            chk(pend, 16'h0001 << ids[k]);
            @(posedge clk);
            cpu.sw_clear <= '1;
            @(posedge clk);
            cpu.sw_clear <= '0;
        end
    endtask
    task automatic t_priority;
        @(posedge clk);
        cfg.src_enable <= '1;
        cfg.global_enable <= 1'b1;
        cfg.prio <= 28'h0 | (28'h3 << (2 * SRC_SPI));
        evt <= '{timer: 4'h1, spi: 1'b1, default: '0};
        @(posedge clk);
        evt <= '0;
        cyc(3);
        chk({irq.req, irq.id, irq.level}, {9'h0, 1'b1, 4'hb, 2'h3});
        @(posedge clk);
        cpu.ack <= 1'b1;
        cpu.ack_id <= 4'hb;
        @(posedge clk);
        cpu.ack <= 1'b0;
        cyc(3);
        chk({irq.req, irq.id, irq.level}, {9'h0, 1'b1, 4'h1, 2'h0});
        chk(pend, 16'h0002);
        @(posedge clk);
        cpu.in_service <= 1'b1;
        cyc(3);
        chk(irq.req, 16'h0000);
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        rst = 1'b1;
        le_cmd = '1;
        eo_cmd = '1;
        pc_cmd = '1;
        cfg = '0;
        cpu = '0;
        evt = '0;
        err_total = 0;
        tests_run = 0;
        wake_cnt = 0;
        grant_cnt = 0;
        refuse_cnt = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        cyc(1);
        t_reset();
        t_edge_only();
        t_level();
        t_pin_change();
        t_power_down();
        t_sources();
        t_priority();
        report_and_stop();
    end
    // A hang counts as a mismatch
    initial begin
        #200000;
        err_total++;
        report_and_stop();
    end
endmodule
